// File: verif/ptu_dma_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ptu_consts.svh"
module ptu_dma_tb;
  logic clk, reset_n, ce, irq, mem_req, mem_write, mem_ack, mem_err, slow, crc_reset;
  logic crc_channel_enable, input_bit_reverse, result_bit_reverse, input_complement;
  logic result_complement, crc_wdata_valid, crc_trigger, crc_done_clear, crc_error_clear;
  logic crc_done_int_enable, crc_busy, crc_block_done_flag, crc_error;
  logic [8:0] channel_enable_bit, transfer_trigger_bit, channel_soft_reset, error_clear;
  logic [8:0] done_clear, done_int_enable, source_address_mode, destination_address_mode;
  logic [8:0] channel_busy, block_done_flag, channel_error;
  logic [17:0] transfer_mode, peripheral_width_select;
  logic [287:0] source_addr, dest_addr;
  logic [143:0] byte_count;
  logic [1:0] mem_size, crc_mode, cpu_write_length;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, err_addr, crc_seed, crc_wdata, crc_dma_addr;
  logic [31:0] crc_checksum, a, d, s, x, r;
  logic [15:0] crc_dma_count;
  logic [63:0] e;
  logic [63:0] exp_q[$];
  int num_errors, samples_checked;
  ptu_dma dut (.*);
  ptu_mem_model mem (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] pat(logic [31:0] v);
    return {v[15:0] ^ 16'h5A5A, v[15:0]};
  endfunction
  function automatic logic [31:0] crc(logic [1:0] m, logic [31:0] st, logic [31:0] dt, int nb,
                                      logic rv = 1'b0);
    logic [31:0] p, k;
    logic f;
    p = m == `PTU_CRC_CCITT ? `PTU_POLY_CCITT : m == `PTU_CRC_8 ? `PTU_POLY_8 :
        m == `PTU_CRC_16 ? `PTU_POLY_16 : `PTU_POLY_32;
    k = m == `PTU_CRC_32 ? `PTU_MASK_32 : m == `PTU_CRC_8 ? `PTU_MASK_8 : `PTU_MASK_16;
    st = st & k;
    for (int b = 0; b < nb * 8; b++) begin
      f = ((st & ~(k >> 1)) != 32'h0) ^ dt[b / 8 * 8 + (rv ? b % 8 : 7 - b % 8)];
      st = ((st << 1) & k) ^ (f ? p : 32'h0);
    end
    return st;
  endfunction
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic start(int c, logic [1:0] md, logic [1:0] fx, int n, int u = 4);
    a = $urandom & 32'h0000_7FFC;
    d = ($urandom & 32'h0000_7FFC) | 32'h0000_8000;
    source_addr[32*c +: 32] = a;
    dest_addr[32*c +: 32] = d;
    byte_count[16*c +: 16] = 16'(n * u);
    transfer_mode[2*c +: 2] = md;
    peripheral_width_select[2*c +: 2] = u == 1 ? `PTU_WID_BYTE :
                                        u == 2 ? `PTU_WID_HALF : `PTU_WID_WORD;
    {destination_address_mode[c], source_address_mode[c]} = fx;
    for (int k = 0; k < n; k++)
      exp_q.push_back({fx[1] ? d : d + u * k, pat(fx[0] ? a : a + u * k)});
    transfer_trigger_bit[c] = 1'b1;
  endtask
  task automatic wait_done(int c);
    tick(1);
    transfer_trigger_bit = '0;
    for (int i = 0; i < 300 && !(block_done_flag[c] | channel_error[c]); i++) tick(1);
    tick(2);
  endtask
  task summarize;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (mem_req && mem_write && mem_ack && !mem_err) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 64'hX;
      check("write addr", mem_addr, e[63:32]);
      check("write data", mem_wdata, e[31:0]);
    end
  end
  initial begin
    #200000;
    num_errors++;
    summarize;
  end
  initial begin
    {ce, reset_n, slow, crc_reset, input_bit_reverse, result_bit_reverse, input_complement} = '0;
    {result_complement, crc_wdata_valid, crc_trigger, crc_done_clear, crc_error_clear} = '0;
    {transfer_trigger_bit, channel_soft_reset, error_clear, done_clear, done_int_enable} = '0;
    {source_address_mode, destination_address_mode, transfer_mode, byte_count} = '0;
    {peripheral_width_select, source_addr, dest_addr, crc_dma_addr, crc_dma_count} = '0;
    {crc_done_int_enable, crc_mode, cpu_write_length, crc_seed, crc_wdata} = '0;
    {ce, crc_channel_enable, channel_enable_bit, err_addr} = '1;
    void'($urandom(32'h6e3e));
    tick(12);
    reset_n = 1'b1;
    tick(1);
    done_int_enable[2] = 1'b1;
    start(2, `PTU_MODE_M2M, 2'h0, 3);
    wait_done(2);
    check("done", block_done_flag[2], 1'b1);
    check("irq", irq, 1'b1);
    done_clear[2] = 1'b1;
    tick(1);
    done_clear = '0;
    tick(2);
    check("irq cleared", irq, 1'b0);
    $display("test m2m finished");
    // byte units at fixed addresses, slow memory
    slow = 1'b1;
    start(0, `PTU_MODE_P2M, 2'h3, 2, 1);
    wait_done(0);
    check("fixed done", block_done_flag[0], 1'b1);
    slow = 1'b0;
    $display("test fixed finished");
    // lower channel first, half-word units on channel 1
    start(1, `PTU_MODE_M2P, 2'h0, 2, 2);
    start(5, `PTU_MODE_M2P, 2'h0, 2);
    wait_done(5);
    check("late done", block_done_flag[5] & block_done_flag[1], 1'b1);
    check("irq masked", irq, 1'b0);
    $display("test priority finished");
    // disable during the first read, then resume
    start(4, `PTU_MODE_M2M, 2'h0, 2);
    tick(1);
    transfer_trigger_bit = '0;
    tick(1);
    channel_enable_bit[4] = 1'b0;
    tick(10);
    check("halted", channel_busy[4] & !block_done_flag[4], 1'b1);
    channel_enable_bit[4] = 1'b1;
    wait_done(4);
    check("resumed", block_done_flag[4], 1'b1);
    $display("test disable finished");
    start(3, `PTU_MODE_M2M, 2'h0, 1);
    err_addr = a;
    wait_done(3);
    exp_q.delete();
    check("error", channel_error[3] & !channel_busy[3], 1'b1);
    transfer_trigger_bit[3] = 1'b1;
    tick(1);
    transfer_trigger_bit = '0;
    tick(3);
    check("refused", channel_busy[3], 1'b0);
    err_addr = '1;
    error_clear[3] = 1'b1;
    tick(1);
    error_clear = '0;
    channel_soft_reset[3] = 1'b1;
    tick(1);
    channel_soft_reset = '0;
    start(3, `PTU_MODE_M2M, 2'h0, 2);
    wait_done(3);
    check("restart", block_done_flag[3], 1'b1);
    $display("test error finished");
    for (int m = 0; m < 4; m++) begin
      crc_mode = 2'(m);
      s = $urandom;
      crc_seed = s;
      cpu_write_length = m == 1 ? `PTU_LEN_BYTE : m == 2 ? `PTU_LEN_HALF : 2'h2;
      {input_complement, result_complement} = {2{m == 1}};
      {input_bit_reverse, result_bit_reverse} = {2{m == 3}};
      crc_reset = 1'b1;
      tick(1);
      crc_reset = 1'b0;
      crc_wdata = $urandom;
      crc_wdata_valid = 1'b1;
      tick(1);
      crc_wdata_valid = 1'b0;
      tick(7);
      x = crc(crc_mode, s, m == 1 ? ~crc_wdata : crc_wdata, m == 1 ? 1 : m == 2 ? 2 : 4, m == 3);
      for (int i = 0; i < 32; i++) r[i] = x[m == 3 ? 31 - i : i];
      check("checksum", crc_checksum, m == 1 ? ~r & `PTU_MASK_8 : r);
    end
    $display("test crc pio finished");
    {input_bit_reverse, result_bit_reverse} = 2'h0;
    {input_complement, result_complement, crc_done_int_enable} = 3'h1;
    crc_reset = 1'b1;
    tick(1);
    crc_reset = 1'b0;
    crc_dma_addr = $urandom & 32'h0000_FFFC;
    crc_dma_count = 16'h0006;
    crc_trigger = 1'b1;
    tick(1);
    crc_trigger = 1'b0;
    for (int i = 0; i < 300 && !crc_block_done_flag; i++) tick(1);
    tick(2);
    x = crc(crc_mode, crc(crc_mode, s, pat(crc_dma_addr), 4), pat(crc_dma_addr + 4), 2);
    check("dma checksum", crc_checksum, x);
    check("crc irq", irq, 1'b1);
    crc_done_clear = 1'b1;
    tick(1);
    crc_done_clear = 1'b0;
    tick(2);
    check("crc done cleared", crc_block_done_flag, 1'b0);
    check("writes left", exp_q.size(), 0);
    $display("test crc dma finished");
    summarize;
  end
endmodule // ptu_dma_tb
`default_nettype wire

// File: verif/ptu_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ptu_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // master port
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_ack,
  output logic mem_err,
  output logic [31:0] mem_rdata,
  // pace and fault control
  input wire logic slow,
  input wire logic [31:0] err_addr
);
  logic [1:0] wait_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_reg <= 2'h0;
      mem_ack <= 1'b0;
    end else begin
      mem_ack <= mem_req && !mem_ack && (!slow || wait_reg == 2'h2);
      wait_reg <= (mem_req && !mem_ack) ? wait_reg + 2'h1 : 2'h0;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_rdata <= 32'h0;
      mem_err <= 1'b0;
    end else begin
      mem_rdata <= mem_req ? {mem_addr[15:0] ^ 16'h5A5A, mem_addr[15:0]} : ~mem_rdata;
      mem_err <= mem_req && !mem_ack && mem_addr == err_addr;
    end
  end
endmodule // ptu_mem_model
`default_nettype wire

// File: verilog/ptu_consts.svh
`ifndef PTU_CONSTS_SVH
`define PTU_CONSTS_SVH
// ****************************************
// channel structure
// ****************************************
`define PTU_NCH 9
`define PTU_CRC_ID 4'h9
`define PTU_FIFO_DEPTH 8
// ****************************************
// transfer type, width and bus size codes
// ****************************************
`define PTU_MODE_M2M 2'h0
`define PTU_MODE_P2M 2'h1
`define PTU_MODE_M2P 2'h2
`define PTU_WID_WORD 2'h0
`define PTU_WID_BYTE 2'h1
`define PTU_WID_HALF 2'h2
`define PTU_SIZE_BYTE 2'h0
`define PTU_SIZE_HALF 2'h1
`define PTU_SIZE_WORD 2'h2
`define PTU_UNIT_BYTE 16'h0001
`define PTU_UNIT_HALF 16'h0002
`define PTU_UNIT_WORD 16'h0004
`define PTU_ADDR_STEP 32'h0000_0004
// ****************************************
// crc polynomial modes
// ****************************************
`define PTU_CRC_CCITT 2'h0
`define PTU_CRC_8 2'h1
`define PTU_CRC_16 2'h2
`define PTU_CRC_32 2'h3
`define PTU_POLY_CCITT 32'h0000_1021
`define PTU_POLY_8 32'h0000_0007
`define PTU_POLY_16 32'h0000_8005
`define PTU_POLY_32 32'h04C1_1DB7
`define PTU_TOP_16 5'h0F
`define PTU_TOP_8 5'h07
`define PTU_TOP_32 5'h1F
`define PTU_MASK_16 32'h0000_FFFF
`define PTU_MASK_8 32'h0000_00FF
`define PTU_MASK_32 32'hFFFF_FFFF
`define PTU_LEN_BYTE 2'h0
`define PTU_LEN_HALF 2'h1
`define PTU_NB_1 3'h1
`define PTU_NB_2 3'h2
`define PTU_NB_4 3'h4
`endif

// File: verilog/ptu_dma.sv
`timescale 1ns/100ps
`default_nettype none
`include "ptu_consts.svh"
module ptu_dma (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // channel control, one bit or field per channel
  input wire logic [`PTU_NCH-1:0] channel_enable_bit,
  input wire logic [`PTU_NCH-1:0] transfer_trigger_bit,
  input wire logic [`PTU_NCH-1:0] channel_soft_reset,
  input wire logic [`PTU_NCH-1:0] error_clear,
  input wire logic [`PTU_NCH-1:0] done_clear,
  input wire logic [`PTU_NCH-1:0] done_int_enable,
  input wire logic [`PTU_NCH-1:0] source_address_mode,
  input wire logic [`PTU_NCH-1:0] destination_address_mode,
  input wire logic [2*`PTU_NCH-1:0] transfer_mode,
  input wire logic [2*`PTU_NCH-1:0] peripheral_width_select,
  input wire logic [32*`PTU_NCH-1:0] source_addr,
  input wire logic [32*`PTU_NCH-1:0] dest_addr,
  input wire logic [16*`PTU_NCH-1:0] byte_count,
  // channel status
  output logic [`PTU_NCH-1:0] channel_busy,
  output logic [`PTU_NCH-1:0] block_done_flag,
  output logic [`PTU_NCH-1:0] channel_error,
  output logic irq,
  // data master port
  output logic mem_req,
  output logic mem_write,
  output logic [1:0] mem_size,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic [31:0] mem_rdata,
  // crc control
  input wire logic crc_channel_enable,
  input wire logic crc_reset,
  input wire logic [1:0] crc_mode,
  input wire logic input_bit_reverse,
  input wire logic result_bit_reverse,
  input wire logic input_complement,
  input wire logic result_complement,
  input wire logic [1:0] cpu_write_length,
  input wire logic [31:0] crc_seed,
  input wire logic [31:0] crc_wdata,
  input wire logic crc_wdata_valid,
  input wire logic crc_trigger,
  input wire logic [31:0] crc_dma_addr,
  input wire logic [15:0] crc_dma_count,
  input wire logic crc_done_clear,
  input wire logic crc_error_clear,
  input wire logic crc_done_int_enable,
  // crc status
  output logic [31:0] crc_checksum,
  output logic crc_busy,
  output logic crc_block_done_flag,
  output logic crc_error
);
  ptu_pkg::ptu_state_t st;
  logic [3:0] act;
  logic [3:0] gnt;
  logic [`PTU_NCH-1:0] req;
  logic [31:0] src_reg [`PTU_NCH];
  logic [31:0] dst_reg [`PTU_NCH];
  logic [15:0] cnt_reg [`PTU_NCH];
  logic [31:0] stage_reg [`PTU_NCH];
  logic [1:0] unit_sz [`PTU_NCH];
  logic [15:0] unit_b [`PTU_NCH];
  logic rd_ok;
  logic wr_ok;
  logic beat_err;
  logic [31:0] crc_addr;
  logic [15:0] fetch_left;
  logic crc_go;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [31:0] fifo_out_data;
  logic [31:0] crc_state;
  logic [31:0] crc_shift;
  logic [2:0] crc_nbytes;
  logic [15:0] crc_left;
  logic crc_active;
  logic crc_start;
  logic pio_go;
  logic [31:0] din;
  logic [31:0] res_mask;

  // ****************************************
  // crc helpers
  // ****************************************
  function automatic logic [4:0] crc_top(input logic [1:0] m);
    case (m)
      `PTU_CRC_8: crc_top = `PTU_TOP_8;
      `PTU_CRC_32: crc_top = `PTU_TOP_32;
      default: crc_top = `PTU_TOP_16;
    endcase
  endfunction

  function automatic logic [31:0] crc_mask(input logic [1:0] m);
    case (m)
      `PTU_CRC_8: crc_mask = `PTU_MASK_8;
      `PTU_CRC_32: crc_mask = `PTU_MASK_32;
      default: crc_mask = `PTU_MASK_16;
    endcase
  endfunction

  function automatic logic [31:0] crc_step(input logic [31:0] s, input logic [7:0] d,
                                           input logic [1:0] m);
    logic [31:0] c;
    logic [31:0] p;
    logic fb;
    c = s;
    case (m)
      `PTU_CRC_CCITT: p = `PTU_POLY_CCITT;
      `PTU_CRC_8: p = `PTU_POLY_8;
      `PTU_CRC_16: p = `PTU_POLY_16;
      default: p = `PTU_POLY_32;
    endcase
    for (int b = 7; b >= 0; b--) begin
      fb = c[crc_top(m)] ^ d[b];
      c = c << 1;
      if (fb) c = c ^ p;
    end
    crc_step = c & crc_mask(m);
  endfunction

  // ****************************************
  // per-channel state
  // ****************************************
  assign rd_ok = (st == ptu_pkg::PTU_E_RD) && mem_ack && !mem_err;
  assign wr_ok = (st == ptu_pkg::PTU_E_WR) && mem_ack && !mem_err;
  assign beat_err = (st == ptu_pkg::PTU_E_RD || st == ptu_pkg::PTU_E_WR) && mem_ack && mem_err;

  for (genvar gi = 0; gi < `PTU_NCH; gi++) begin : g_ch
    logic hit;
    logic start;
    logic last;
    // memory-to-memory moves words, peripheral types use width
    always_comb begin
      if (transfer_mode[2*gi+:2] == `PTU_MODE_M2M) unit_sz[gi] = `PTU_SIZE_WORD;
      else if (peripheral_width_select[2*gi+:2] == `PTU_WID_BYTE) unit_sz[gi] = `PTU_SIZE_BYTE;
      else if (peripheral_width_select[2*gi+:2] == `PTU_WID_HALF) unit_sz[gi] = `PTU_SIZE_HALF;
      else unit_sz[gi] = `PTU_SIZE_WORD;
    end
    assign unit_b[gi] = (unit_sz[gi] == `PTU_SIZE_BYTE) ? `PTU_UNIT_BYTE :
                        (unit_sz[gi] == `PTU_SIZE_HALF) ? `PTU_UNIT_HALF : `PTU_UNIT_WORD;
    assign hit = (act == 4'(gi));
    // no restart while an error stands
    assign start = transfer_trigger_bit[gi] && channel_enable_bit[gi] && !channel_error[gi]
                   && !channel_busy[gi] && !channel_soft_reset[gi];
    assign last = hit && wr_ok && (cnt_reg[gi] <= unit_b[gi]);
    assign req[gi] = channel_busy[gi] && channel_enable_bit[gi] && !channel_error[gi];

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        channel_busy[gi] <= 1'b0;
        channel_error[gi] <= 1'b0;
        block_done_flag[gi] <= 1'b0;
      end else if (ce) begin
        // run from trigger until the count is spent
        if (channel_soft_reset[gi]) channel_busy[gi] <= 1'b0;
        else if (start) channel_busy[gi] <= byte_count[16*gi+:16] != '0;
        else if ((hit && beat_err) || last) channel_busy[gi] <= 1'b0;
        // error stands until software clears it
        if (hit && beat_err) channel_error[gi] <= 1'b1;
        else if (error_clear[gi]) channel_error[gi] <= 1'b0;
        if (last || (start && byte_count[16*gi+:16] == '0)) block_done_flag[gi] <= 1'b1;
        else if (done_clear[gi]) block_done_flag[gi] <= 1'b0;
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        src_reg[gi] <= '0;
        dst_reg[gi] <= '0;
        cnt_reg[gi] <= '0;
        stage_reg[gi] <= '0;
      end else if (ce) begin
        if (channel_soft_reset[gi]) begin
          cnt_reg[gi] <= '0;
        end else if (start) begin
          src_reg[gi] <= source_addr[32*gi+:32];
          dst_reg[gi] <= dest_addr[32*gi+:32];
          cnt_reg[gi] <= byte_count[16*gi+:16];
        end else if (hit && wr_ok) begin
          if (!source_address_mode[gi]) src_reg[gi] <= src_reg[gi] + 32'(unit_b[gi]);
          if (!destination_address_mode[gi]) dst_reg[gi] <= dst_reg[gi] + 32'(unit_b[gi]);
          cnt_reg[gi] <= last ? '0 : cnt_reg[gi] - unit_b[gi];
        end
        // read word parks in the channel staging register
        if (hit && rd_ok) stage_reg[gi] <= mem_rdata;
      end
    end
  end

  always_comb begin
    gnt = '0;
    for (int i = `PTU_NCH - 1; i >= 0; i--) begin
      if (req[i]) gnt = 4'(i);
    end
  end

  // ****************************************
  // bus engine
  // ****************************************
  assign crc_go = crc_active && (fetch_left != '0) && fifo_in_ready;
  assign fifo_in_valid = (st == ptu_pkg::PTU_E_CRC_RD) && mem_ack && !mem_err;

  // single master port shared by channels and crc fetches
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= ptu_pkg::PTU_E_IDLE;
      act <= '0;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_size <= `PTU_SIZE_WORD;
      mem_addr <= '0;
      mem_wdata <= '0;
    end else if (ce) begin
      case (st)
        ptu_pkg::PTU_E_IDLE: begin
          if (req != '0) begin
            act <= gnt;
            mem_req <= 1'b1;
            mem_write <= 1'b0;
            mem_size <= unit_sz[gnt];
            mem_addr <= src_reg[gnt];
            st <= ptu_pkg::PTU_E_RD;
          end else if (crc_go) begin
            act <= `PTU_CRC_ID;
            mem_req <= 1'b1;
            mem_write <= 1'b0;
            mem_size <= `PTU_SIZE_WORD;
            mem_addr <= crc_addr;
            st <= ptu_pkg::PTU_E_CRC_RD;
          end
        end
        ptu_pkg::PTU_E_RD: begin
          if (mem_ack) begin
            // a disabled channel gets no write beat
            if (!mem_err && channel_enable_bit[act]) begin
              mem_write <= 1'b1;
              mem_addr <= dst_reg[act];
              mem_wdata <= mem_rdata;
              st <= ptu_pkg::PTU_E_WR;
            end else begin
              mem_req <= 1'b0;
              st <= ptu_pkg::PTU_E_IDLE;
            end
          end
        end
        ptu_pkg::PTU_E_WR, ptu_pkg::PTU_E_CRC_RD: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            st <= ptu_pkg::PTU_E_IDLE;
          end
        end
        default: begin
          mem_req <= 1'b0;
          st <= ptu_pkg::PTU_E_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // crc fetch side
  // ****************************************
  assign crc_start = crc_trigger && crc_channel_enable && !crc_active && !crc_error;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_addr <= '0;
      fetch_left <= '0;
      crc_error <= 1'b0;
    end else if (ce) begin
      if (crc_start) begin
        crc_addr <= crc_dma_addr;
        fetch_left <= crc_dma_count;
      end else if (!crc_channel_enable || (mem_ack && mem_err && st == ptu_pkg::PTU_E_CRC_RD)) begin
        fetch_left <= '0;
      end else if (fifo_in_valid) begin
        crc_addr <= crc_addr + `PTU_ADDR_STEP;
        fetch_left <= (fetch_left > `PTU_UNIT_WORD) ? fetch_left - `PTU_UNIT_WORD : '0;
      end
      if (mem_ack && mem_err && st == ptu_pkg::PTU_E_CRC_RD) crc_error <= 1'b1;
      else if (crc_error_clear) crc_error <= 1'b0;
    end
  end

  ptu_fifo #(
    .WIDTH(32),
    .DEPTH(`PTU_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .flush(crc_start),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(mem_rdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ****************************************
  // crc engine
  // ****************************************
  assign fifo_out_ready = crc_active && (crc_nbytes == '0);
  assign pio_go = crc_wdata_valid && crc_channel_enable && !crc_active && (crc_nbytes == '0);

  // data inverted, then bit order flipped inside each byte
  always_comb begin
    din = (crc_active ? fifo_out_data : crc_wdata) ^ {32{input_complement}};
    if (input_bit_reverse) begin
      for (int k = 0; k < 32; k++) din[k] = input_complement ^
        (crc_active ? fifo_out_data[(k/8)*8+7-k%8] : crc_wdata[(k/8)*8+7-k%8]);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_state <= '0;
    end else if (ce) begin
      if (crc_reset) crc_state <= crc_seed;
      else if (crc_nbytes != '0) crc_state <= crc_step(crc_state, crc_shift[7:0], crc_mode);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_shift <= '0;
      crc_nbytes <= '0;
      crc_left <= '0;
      crc_active <= 1'b0;
      crc_block_done_flag <= 1'b0;
    end else if (ce) begin
      if (crc_nbytes != '0) begin
        crc_shift <= crc_shift >> 8;
        crc_nbytes <= crc_nbytes - 1'b1;
      end else if (crc_active && fifo_out_valid) begin
        crc_shift <= din;
        crc_nbytes <= (crc_left >= `PTU_UNIT_WORD) ? `PTU_NB_4 : crc_left[2:0];
        crc_left <= (crc_left >= `PTU_UNIT_WORD) ? crc_left - `PTU_UNIT_WORD : '0;
      end else if (pio_go) begin
        // processor write, one byte per cycle
        crc_shift <= din;
        crc_nbytes <= (cpu_write_length == `PTU_LEN_BYTE) ? `PTU_NB_1 :
                      (cpu_write_length == `PTU_LEN_HALF) ? `PTU_NB_2 : `PTU_NB_4;
      end
      if (crc_start) crc_left <= crc_dma_count;
      if (crc_start) crc_active <= 1'b1;
      else if (!crc_channel_enable || crc_error) crc_active <= 1'b0;
      else if (crc_active && crc_left == '0 && crc_nbytes == '0 && !fifo_out_valid)
        crc_active <= 1'b0;
      if (crc_active && crc_channel_enable && !crc_error && crc_left == '0 && crc_nbytes == '0
          && !fifo_out_valid) crc_block_done_flag <= 1'b1;
      else if (crc_done_clear) crc_block_done_flag <= 1'b0;
    end
  end

  // ****************************************
  // status outputs
  // ****************************************
  assign res_mask = crc_mask(crc_mode);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_checksum <= '0;
      crc_busy <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      // result reversed over the polynomial width, then inverted
      for (int k = 0; k < 32; k++) begin
        crc_checksum[k] <= res_mask[k] & (result_complement ^
          (result_bit_reverse ? (k <= crc_top(crc_mode) && crc_state[crc_top(crc_mode)-k])
                              : crc_state[k]));
      end
      crc_busy <= crc_active || (crc_nbytes != '0);
      // enabled done flags reach the interrupt
      irq <= ((block_done_flag & done_int_enable) != '0)
             || (crc_block_done_flag && crc_done_int_enable);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n || !ce);

  a_stage_to_write: assert property (rd_ok && channel_enable_bit[act] |=>
    mem_req && mem_write && mem_wdata == stage_reg[act]) else $error("staged word not written");
  a_disable_halts: assert property (st == ptu_pkg::PTU_E_RD && mem_ack &&
    !channel_enable_bit[act] |=> !mem_req ##1 !mem_write) else $error("disabled channel wrote");
  a_lowest_wins: assert property (st == ptu_pkg::PTU_E_IDLE && req[0] |=>
    act == 4'h0 && st == ptu_pkg::PTU_E_RD) else $error("channel 0 not granted");
  a_done_on_last: assert property (wr_ok && cnt_reg[act] <= unit_b[act] |=>
    block_done_flag[$past(act)] && !channel_busy[$past(act)]) else $error("no done at end");
  a_error_stops: assert property (beat_err |=> channel_error[$past(act)]
    && !channel_busy[$past(act)] && !mem_req) else $error("error did not stop channel");
  a_irq_gated: assert property (irq |-> $past((block_done_flag & done_int_enable) != '0
    || (crc_block_done_flag && crc_done_int_enable))) else $error("ungated interrupt");
  a_word_four: assert property (pio_go && !crc_reset && cpu_write_length == 2'h2 |=>
    crc_nbytes == 3'h4 ##3 crc_nbytes == 3'h1 ##1 crc_nbytes == 3'h0)
    else $error("word write not four cycles");
  a_seed_load: assert property (crc_reset |=> crc_state == $past(crc_seed))
    else $error("seed not loaded");
  a_crc_fetch_word: assert property (crc_go && req == '0 && st == ptu_pkg::PTU_E_IDLE
    |=> mem_size == `PTU_SIZE_WORD && st == ptu_pkg::PTU_E_CRC_RD) else $error("bad crc fetch");

  c_chan_done: cover property (wr_ok ##1 block_done_flag != '0);
  c_two_chan: cover property (req[0] && req[8]);
  c_crc_dma_done: cover property (crc_active ##[1:200] crc_block_done_flag);
  c_fifo_full: cover property (crc_active && !fifo_in_ready);
endmodule // ptu_dma
`default_nettype wire

// File: verilog/ptu_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module ptu_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic wr;
  logic ld;

  assign in_ready = count < (AW+1)'(DEPTH);
  assign wr = in_valid && in_ready;
  // head word moves into the output register when it is free
  assign ld = (count != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk) begin
    if (ce && wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (ce) begin
      if (flush) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        count <= '0;
      end else begin
        if (wr) wr_ptr <= wr_ptr + 1'b1;
        if (ld) rd_ptr <= rd_ptr + 1'b1;
        if (wr && !ld) count <= count + 1'b1;
        else if (ld && !wr) count <= count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (ce) begin
      if (flush) begin
        out_valid <= 1'b0;
      end else if (ld) begin
        out_valid <= 1'b1;
        out_data <= mem[rd_ptr];
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule // ptu_fifo
`default_nettype wire

// File: verilog/ptu_pkg.sv
package ptu_pkg;
  typedef enum logic [1:0] {
    PTU_E_IDLE = 2'h0,
    PTU_E_RD = 2'h1,
    PTU_E_WR = 2'h2,
    PTU_E_CRC_RD = 2'h3
  } ptu_state_t;
endpackage
